/* logic/rtctb_pkg.sv */
/*
 Constants, field layout and mode states of the count-clock time base
 and run control front end of a real-time clock chain.
 Assumes a single system clock of 100 MHz and a count clock arriving on a pin.
*/
// How it works
// - Prescaler bit picks direct or divide-by-eight input.
// - Asynchronous mode keeps counting without bus involvement.
// - Asynchronous mode ignores writes to chain registers.
// - Mode select bit: zero synchronous, one asynchronous.
// - Soft reset gives synchronous mode, prescaler on.
// - Bit fifteen shows full access possible, resets one; code also shows it during the switch to asynchronous mode.
// - Flag clears once asynchronous mode is established.
// - Flag sets once synchronous mode is restored.
// - Add bit inserts one extra pulse, self-clears.
// - Skip bit suppresses next pulse, self-clears.
// - Add and skip together leave counts unchanged.
// - Run bit stops or allows counting, resets one.
// - Disable bit in system register stops chain completely.
// - Soft reset restores chain registers, self-clears.
// - System reset spares chain, resets interrupt control.
// - Timer overflow requests join one common request.
package rtctb_pkg;
   // Register byte addresses
   localparam logic [15:0] CTRL_OFF = 16'hF110;
   localparam logic [15:0] CFGA_OFF = 16'hF114;
   localparam logic [15:0] CFGB_OFF = 16'hF118;
   localparam logic [15:0] TIMER_OFF = 16'hF11C;
   localparam logic [15:0] ICTL_OFF = 16'hF120;
   // Field positions
   localparam int RUN_BIT = 0;
   localparam int PRE_BIT = 1;
   localparam int SKIP_BIT = 2;
   localparam int ADD_BIT = 3;
   localparam int ACC_BIT = 15;
   localparam int MODE_BIT = 0;
   localparam int SRST_BIT = 1;
   localparam int DIS_BIT = 0;
   localparam int IEN_BIT = 0;
   localparam int IREQ_BIT = 1;
   // Reset values, timing and response codes
   localparam logic [15:0] CTRL_RESET = 16'h8003;
   localparam int SYS_TO_CNT_RATIO = 4;
   localparam int PRE_DIV_W = 3;
   localparam logic [PRE_DIV_W-1:0] PRE_DIV_LAST = 3'h7;
   localparam logic [1:0] MODE_SETTLE = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {MODE_SYNC, MODE_TO_ASYNC, MODE_ASYNC, MODE_TO_SYNC} rtctb_mode_t;
endpackage

/* logic/rtctb_edge_sync.sv */
/*
 Three-stage synchroniser with rising-edge detect for the count clock pin.
 Assumes the pin toggles no faster than a quarter of aclk.
*/
`timescale 1ns/100ps
`default_nettype none
module rtctb_edge_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin_in,
   output logic event_r
);
   logic s1_r, s2_r, s3_r, lvl_r;
   logic event_nxt, lvl_nxt;

   // Edge counts once stages two and three agree on a new high level;
   // waiting for agreement keeps a late-settling first stage from a false edge
   always_comb begin
      lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
      event_nxt = s2_r & s3_r & ~lvl_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         lvl_r <= 1'b0;
         event_r <= 1'b0;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         lvl_r <= lvl_nxt;
         event_r <= event_nxt;
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   one_event_a: assert property (event_r |=> !event_r)
      else $error("count event longer than one cycle");
endmodule
`default_nettype wire

/* logic/rtctb_prescale.sv */
/*
 Divide-by-eight prescaler and prescale timer with add/skip correction.
 Assumes count events at most one in four aclk cycles; reload is elsewhere.
*/
`timescale 1ns/100ps
`default_nettype none
module rtctb_prescale #(
   parameter int TW = 16
) (
   input wire logic aclk,
   input wire logic chain_rst,
   input wire logic cnt_event,
   input wire logic run,
   input wire logic pre_en,
   input wire logic chain_off,
   input wire logic add_req,
   input wire logic skip_req,
   input wire logic wr_en,
   input wire logic [TW-1:0] wr_data,
   output logic [TW-1:0] timer_r,
   output logic tick_r,
   output logic ovf_r
);
   logic [rtctb_pkg::PRE_DIV_W-1:0] div_r, div_nxt;
   logic [TW-1:0] timer_nxt;
   logic tick, tick_nxt, ovf_nxt;
   logic [1:0] step;
   logic [TW:0] sum;

   // Prescale stage, then correction step applied to the timer
   always_comb begin
      div_nxt = div_r;
      tick = 1'b0;
      step = 2'h1;
      sum = {1'b0, timer_r};
      if (cnt_event && run && !chain_off) begin
         if (pre_en) begin
            div_nxt = div_r + 3'h1;
            tick = (div_r == rtctb_pkg::PRE_DIV_LAST);
         end else begin
            tick = 1'b1;
         end
      end
      if (add_req && !skip_req) begin
         step = 2'h2;
      end else if (skip_req && !add_req) begin
         step = 2'h0;
      end
      if (tick) begin
         sum = {1'b0, timer_r} + {{(TW-1){1'b0}}, step};
      end
      timer_nxt = wr_en ? wr_data : sum[TW-1:0];
      ovf_nxt = tick && sum[TW];
      tick_nxt = tick;
   end

   always_ff @(posedge aclk) begin
      if (chain_rst) begin
         div_r <= '0;
         timer_r <= '0;
         tick_r <= 1'b0;
         ovf_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         timer_r <= timer_nxt;
         tick_r <= tick_nxt;
         ovf_r <= ovf_nxt;
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (chain_rst);

   add_step_a: assert property (tick && add_req && !skip_req && !wr_en
      |=> timer_r == $past(timer_r) + 16'h0002)
      else $error("add pulse did not advance timer by two");
   skip_step_a: assert property (tick && skip_req && !add_req && !wr_en
      |=> timer_r == $past(timer_r))
      else $error("skip pulse did not hold timer");
   both_net_a: assert property (tick && skip_req && add_req && !wr_en
      |=> timer_r == $past(timer_r) + 16'h0001)
      else $error("add with skip changed net count");
   stop_hold_a: assert property ((!run || chain_off) && !wr_en
      |=> timer_r == $past(timer_r) && !tick_r)
      else $error("timer moved while stopped or disabled");
   div_eight_a: assert property (pre_en && cnt_event && div_r != rtctb_pkg::PRE_DIV_LAST
      |-> !tick)
      else $error("prescaler ticked before eighth event");
   add_seen_c: cover property (tick && add_req && !skip_req);
endmodule
`default_nettype wire

/* logic/rtctb_top.sv */
/*
 Top of the count-clock time base: AXI4-Lite slave, control and system
 configuration registers, clocking-mode switch and common interrupt request.
 Assumes one aclk domain; the count clock is a pin sampled by a synchroniser.
 chain_reset_n is the power-on reset of the chain; aresetn is the system reset.
*/
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module rtctb_top #(
   parameter int AW = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic chain_reset_n,
   input wire logic count_clk,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq_req_r
);
   // Bus state
   logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
   logic [AW-1:0] waddr_r, waddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
   logic [1:0] bresp_nxt, rresp_nxt;
   logic [31:0] rdata_nxt;
   logic wr_fire;
   // System-reset state
   logic srst_r, srst_nxt, dis_r, dis_nxt, ien_r, ien_nxt, ireq_r, ireq_nxt, irq_nxt;
   // Chain state
   logic chain_rst;
   logic run_r, run_nxt, pre_r, pre_nxt, add_r, add_nxt, skip_r, skip_nxt;
   logic mode_sel_r, mode_sel_nxt;
   rtctb_pkg::rtctb_mode_t mode_st_r, mode_st_nxt;
   logic [1:0] settle_r, settle_nxt;
   logic acc_flag, writes_ok, timer_wr;
   logic [15:0] wr_merged, ctrl_view;
   logic cnt_event, tick_r, ovf_r;
   logic [15:0] timer_r;

   // True for the addresses that have a register behind them
   function automatic logic reg_hit(input logic [AW-1:0] a);
      reg_hit = (a == rtctb_pkg::CTRL_OFF) || (a == rtctb_pkg::CFGA_OFF) ||
         (a == rtctb_pkg::CFGB_OFF) || (a == rtctb_pkg::TIMER_OFF) ||
         (a == rtctb_pkg::ICTL_OFF);
   endfunction

   // Byte-lane merge of a 16-bit register with write data
   function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d,
         input logic [3:0] s);
      lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // Synchroniser on the chain's power-on reset: a system reset must
   // neither drop nor invent a count edge
   rtctb_edge_sync u_sync (
      .aclk(aclk),
      .aresetn(chain_reset_n),
      .pin_in(count_clk),
      .event_r(cnt_event)
   );

   // Chain reset comes from power-on or the self-clearing soft reset
   assign chain_rst = !chain_reset_n || srst_r;
   assign acc_flag = (mode_st_r == rtctb_pkg::MODE_SYNC) ||
      (mode_st_r == rtctb_pkg::MODE_TO_ASYNC);
   // Writes only while synchronous operation is fully established
   assign writes_ok = (mode_st_r == rtctb_pkg::MODE_SYNC);
   assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
   assign ctrl_view = {acc_flag, 11'h000, add_r, skip_r, pre_r, run_r};
   assign timer_wr = wr_fire && writes_ok && (waddr_r == rtctb_pkg::TIMER_OFF);
   assign wr_merged = lane_merge(
      (waddr_r == rtctb_pkg::TIMER_OFF) ? timer_r : ctrl_view, wdata_r, wstrb_r);

   // Counting runs from the synchronised edge in both modes, so the bus
   // being blocked in asynchronous mode never stalls timekeeping
   rtctb_prescale #(
      .TW(16)
   ) u_pre (
      .aclk(aclk),
      .chain_rst(chain_rst),
      .cnt_event(cnt_event),
      .run(run_r),
      .pre_en(pre_r),
      .chain_off(dis_r),
      .add_req(add_r),
      .skip_req(skip_r),
      .wr_en(timer_wr),
      .wr_data(wr_merged),
      .timer_r(timer_r),
      .tick_r(tick_r),
      .ovf_r(ovf_r)
   );

   // AXI4-Lite handshakes: address and data taken in either order
   always_comb begin
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      waddr_nxt = waddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = s_axi_bvalid;
      bresp_nxt = s_axi_bresp;
      rvalid_nxt = s_axi_rvalid;
      rresp_nxt = s_axi_rresp;
      rdata_nxt = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_nxt = 1'b1;
         waddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_fire) begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = reg_hit(waddr_r) ? rtctb_pkg::RESP_OKAY : rtctb_pkg::RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = reg_hit(s_axi_araddr) ? rtctb_pkg::RESP_OKAY : rtctb_pkg::RESP_SLVERR;
         // Reads stay open in every mode
         unique case (s_axi_araddr)
            rtctb_pkg::CTRL_OFF: rdata_nxt = {16'h0000, ctrl_view};
            rtctb_pkg::CFGA_OFF: rdata_nxt = {30'h00000000, srst_r, mode_sel_r};
            rtctb_pkg::CFGB_OFF: rdata_nxt = {31'h00000000, dis_r};
            rtctb_pkg::TIMER_OFF: rdata_nxt = {16'h0000, timer_r};
            rtctb_pkg::ICTL_OFF: rdata_nxt = {30'h00000000, ireq_r, ien_r};
            default: rdata_nxt = 32'h00000000;
         endcase
      end
      // One write and one read in flight at most
      awready_nxt = !aw_held_nxt && !bvalid_nxt;
      wready_nxt = !w_held_nxt && !bvalid_nxt;
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         waddr_r <= '0;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= rtctb_pkg::RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= rtctb_pkg::RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
      end else begin
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         s_axi_awready <= awready_nxt;
         s_axi_wready <= wready_nxt;
         s_axi_bvalid <= bvalid_nxt;
         s_axi_bresp <= bresp_nxt;
         s_axi_arready <= arready_nxt;
         s_axi_rvalid <= rvalid_nxt;
         s_axi_rresp <= rresp_nxt;
         s_axi_rdata <= rdata_nxt;
      end
   end

   // System-side registers: with the bus state, the only state a system reset touches
   always_comb begin
      srst_nxt = 1'b0;
      dis_nxt = dis_r;
      ien_nxt = ien_r;
      ireq_nxt = ireq_r;
      if (wr_fire && waddr_r == rtctb_pkg::CFGA_OFF && wstrb_r[0]) begin
         srst_nxt = wdata_r[rtctb_pkg::SRST_BIT];
      end
      if (wr_fire && waddr_r == rtctb_pkg::CFGB_OFF && wstrb_r[0]) begin
         dis_nxt = wdata_r[rtctb_pkg::DIS_BIT];
      end
      if (wr_fire && waddr_r == rtctb_pkg::ICTL_OFF && wstrb_r[0]) begin
         ien_nxt = wdata_r[rtctb_pkg::IEN_BIT];
         ireq_nxt = wdata_r[rtctb_pkg::IREQ_BIT];
      end
      // Overflow after the software write so a same-cycle clear loses
      if (ovf_r) begin
         ireq_nxt = 1'b1;
      end
      irq_nxt = ireq_nxt && ien_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         srst_r <= 1'b0;
         dis_r <= 1'b0;
         ien_r <= 1'b0;
         ireq_r <= 1'b0;
         irq_req_r <= 1'b0;
      end else begin
         srst_r <= srst_nxt;
         dis_r <= dis_nxt;
         ien_r <= ien_nxt;
         ireq_r <= ireq_nxt;
         irq_req_r <= irq_nxt;
      end
   end

   // Chain registers and mode switch; no system reset here
   always_comb begin
      run_nxt = run_r;
      pre_nxt = pre_r;
      add_nxt = add_r;
      skip_nxt = skip_r;
      mode_sel_nxt = mode_sel_r;
      mode_st_nxt = mode_st_r;
      settle_nxt = settle_r;
      // Correction consumed: both bits drop together
      if (tick_r) begin
         add_nxt = 1'b0;
         skip_nxt = 1'b0;
      end
      // A software write after the hardware clear wins the same cycle
      if (wr_fire && writes_ok && waddr_r == rtctb_pkg::CTRL_OFF) begin
         run_nxt = wr_merged[rtctb_pkg::RUN_BIT];
         pre_nxt = wr_merged[rtctb_pkg::PRE_BIT];
         add_nxt = wr_merged[rtctb_pkg::ADD_BIT];
         skip_nxt = wr_merged[rtctb_pkg::SKIP_BIT];
      end
      if (wr_fire && waddr_r == rtctb_pkg::CFGA_OFF && wstrb_r[0]) begin
         mode_sel_nxt = wdata_r[rtctb_pkg::MODE_BIT];
      end
      // Settle period models the handover between clocking modes
      unique case (mode_st_r)
         rtctb_pkg::MODE_SYNC: begin
            settle_nxt = 2'h0;
            if (mode_sel_r) begin
               mode_st_nxt = rtctb_pkg::MODE_TO_ASYNC;
            end
         end
         rtctb_pkg::MODE_TO_ASYNC: begin
            settle_nxt = settle_r + 2'h1;
            if (settle_r == rtctb_pkg::MODE_SETTLE) begin
               mode_st_nxt = rtctb_pkg::MODE_ASYNC;
            end
         end
         rtctb_pkg::MODE_ASYNC: begin
            settle_nxt = 2'h0;
            if (!mode_sel_r) begin
               mode_st_nxt = rtctb_pkg::MODE_TO_SYNC;
            end
         end
         rtctb_pkg::MODE_TO_SYNC: begin
            settle_nxt = settle_r + 2'h1;
            if (settle_r == rtctb_pkg::MODE_SETTLE) begin
               mode_st_nxt = rtctb_pkg::MODE_SYNC;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (chain_rst) begin
         run_r <= rtctb_pkg::CTRL_RESET[rtctb_pkg::RUN_BIT];
         pre_r <= rtctb_pkg::CTRL_RESET[rtctb_pkg::PRE_BIT];
         add_r <= rtctb_pkg::CTRL_RESET[rtctb_pkg::ADD_BIT];
         skip_r <= rtctb_pkg::CTRL_RESET[rtctb_pkg::SKIP_BIT];
         mode_sel_r <= 1'b0;
         mode_st_r <= rtctb_pkg::MODE_SYNC;
         settle_r <= 2'h0;
      end else begin
         run_r <= run_nxt;
         pre_r <= pre_nxt;
         add_r <= add_nxt;
         skip_r <= skip_nxt;
         mode_sel_r <= mode_sel_nxt;
         mode_st_r <= mode_st_nxt;
         settle_r <= settle_nxt;
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn || chain_rst);

   async_flag_a: assert property ($rose(mode_sel_r) && mode_st_r == rtctb_pkg::MODE_SYNC
      |=> acc_flag ##[4:6] !acc_flag)
      else $error("access flag did not clear after async select");
   sync_flag_a: assert property ($fell(mode_sel_r) |-> ##[1:12] acc_flag)
      else $error("access flag did not return after sync select");
   write_block_a: assert property (wr_fire && !writes_ok
      && waddr_r == rtctb_pkg::CTRL_OFF
      |=> run_r == $past(run_r) && pre_r == $past(pre_r))
      else $error("control write taken in async mode");
   both_clear_a: assert property (tick_r && add_r && skip_r && !wr_fire
      |=> !add_r && !skip_r)
      else $error("add and skip not both cleared");
   // Own disable: the chain reset it checks must not switch it off
   soft_reset_a: assert property (disable iff (!aresetn)
      wr_fire && waddr_r == rtctb_pkg::CFGA_OFF && wstrb_r[0] && wdata_r[rtctb_pkg::SRST_BIT]
      |=> srst_r ##1 !srst_r && run_r && pre_r && !mode_sel_r)
      else $error("soft reset did not restore chain");
   irq_join_a: assert property (ovf_r && ien_r |=> ##1 irq_req_r)
      else $error("overflow not seen on common request");
   async_reach_c: cover property (mode_st_r == rtctb_pkg::MODE_ASYNC);
   resync_c: cover property (mode_st_r == rtctb_pkg::MODE_TO_SYNC ##[1:8]
      mode_st_r == rtctb_pkg::MODE_SYNC);
   irq_c: cover property ($rose(irq_req_r));
endmodule
`default_nettype wire

/* bench/rtctb_top_tb.sv */
/*
 Self-checking bench for the count-clock time base front end.
 Assumes the design answers on AXI4-Lite and samples count_clk by a synchroniser.
*/
`timescale 1ns/100ps
`default_nettype none
module rtctb_top_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic chain_reset_n = 1'b0;
   logic count_clk = 1'b0;
   logic [15:0] s_axi_awaddr = 16'h0000;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'h3;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [15:0] s_axi_araddr = 16'h0000;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic irq_req_r;
   int error_cnt = 0;
   int checked = 0;
   logic [31:0] d;
   logic [1:0] r;

   rtctb_top #(.AW(16)) i_rtctb_top (.aclk(aclk), .aresetn(aresetn),
      .chain_reset_n(chain_reset_n), .count_clk(count_clk),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_req_r(irq_req_r));

   // 100 MHz system clock
   always #5 aclk = ~aclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      if (n >= 50) error_cnt++;
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [15:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      if (n >= 50) error_cnt++;
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
      rd(a);
      chk(d, exp);
   endtask

   // Count edges spaced well beyond the four-to-one minimum
   task automatic pulses(input int n);
      repeat (n) begin
         count_clk <= 1'b1;
         repeat (5) @(posedge aclk);
         count_clk <= 1'b0;
         repeat (5) @(posedge aclk);
      end
      repeat (8) @(posedge aclk);
   endtask

   // Poll the access flag; the switch takes a few cycles
   task automatic poll(input logic f);
      int n;
      n = 0;
      do begin
         rd(rtctb_pkg::CTRL_OFF);
         n++;
      end while (d[15] !== f && n < 20);
      if (d[15] !== f) error_cnt++;
   endtask

   task automatic t_reset;
      rdchk(rtctb_pkg::CTRL_OFF, 32'h00008003);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000000);
      rd(16'hF124);
      chk({30'h0, r}, {30'h0, rtctb_pkg::RESP_SLVERR});
      chk(d, 32'h00000000);
      $display("test reset values done");
   endtask

   task automatic t_prescale;
      pulses(8);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000001);
      wr(rtctb_pkg::CTRL_OFF, 32'h00000001);
      wr(rtctb_pkg::TIMER_OFF, 32'h00000000);
      pulses(3);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000003);
      $display("test prescaler done");
   endtask

   task automatic t_corr;
      wr(rtctb_pkg::CTRL_OFF, 32'h00000009);
      pulses(1);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000005);
      rdchk(rtctb_pkg::CTRL_OFF, 32'h00008001);
      wr(rtctb_pkg::CTRL_OFF, 32'h00000005);
      pulses(1);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000005);
      rdchk(rtctb_pkg::CTRL_OFF, 32'h00008001);
      wr(rtctb_pkg::CTRL_OFF, 32'h0000000D);
      pulses(1);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000006);
      rdchk(rtctb_pkg::CTRL_OFF, 32'h00008001);
      $display("test correction done");
   endtask

   task automatic t_run;
      wr(rtctb_pkg::CTRL_OFF, 32'h00000000);
      pulses(2);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000006);
      wr(rtctb_pkg::CTRL_OFF, 32'h00000001);
      wr(rtctb_pkg::CFGB_OFF, 32'h00000001);
      pulses(2);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000006);
      wr(rtctb_pkg::CFGB_OFF, 32'h00000000);
      pulses(1);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000007);
      $display("test run and disable done");
   endtask

   task automatic t_async;
      wr(rtctb_pkg::CTRL_OFF, 32'h00000003);
      wr(rtctb_pkg::CFGA_OFF, 32'h00000001);
      poll(1'b0);
      chk(d, 32'h00000003);
      wr(rtctb_pkg::TIMER_OFF, 32'h00001234);
      chk({30'h0, r}, {30'h0, rtctb_pkg::RESP_OKAY});
      wr(rtctb_pkg::CTRL_OFF, 32'h00000000);
      rdchk(rtctb_pkg::CTRL_OFF, 32'h00000003);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000007);
      pulses(8);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000008);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000008);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000008);
      wr(rtctb_pkg::CFGA_OFF, 32'h00000000);
      poll(1'b1);
      chk(d, 32'h00008003);
      $display("test clocking modes done");
   endtask

   // System reset must spare the chain but clear interrupt control
   task automatic t_sysrst;
      wr(rtctb_pkg::ICTL_OFF, 32'h00000001);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rdchk(rtctb_pkg::CTRL_OFF, 32'h00008003);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000008);
      rdchk(rtctb_pkg::ICTL_OFF, 32'h00000000);
      $display("test system reset done");
   endtask

   task automatic t_srst;
      wr(rtctb_pkg::CFGA_OFF, 32'h00000002);
      rdchk(rtctb_pkg::CTRL_OFF, 32'h00008003);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000000);
      rdchk(rtctb_pkg::CFGA_OFF, 32'h00000000);
      $display("test soft reset done");
   endtask

   // Overflow raises the common request while enabled; writing zero to interrupt control drops it
   task automatic t_irq;
      wr(rtctb_pkg::CTRL_OFF, 32'h00000001);
      wr(rtctb_pkg::ICTL_OFF, 32'h00000001);
      wr(rtctb_pkg::TIMER_OFF, 32'h0000FFFF);
      chk({31'h0, irq_req_r}, 32'h00000000);
      pulses(1);
      rdchk(rtctb_pkg::TIMER_OFF, 32'h00000000);
      chk({31'h0, irq_req_r}, 32'h00000001);
      rdchk(rtctb_pkg::ICTL_OFF, 32'h00000003);
      wr(rtctb_pkg::ICTL_OFF, 32'h00000000);
      chk({31'h0, irq_req_r}, 32'h00000000);
      $display("test interrupt request done");
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Both resets held four cycles at the start
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      chain_reset_n <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_prescale();
      t_corr();
      t_run();
      t_async();
      t_sysrst();
      t_srst();
      t_irq();
      summarize();
   end

   // Tests need under a thousand cycles; twenty thousand means a hang
   initial begin
      #200000;
      error_cnt++;
      summarize();
   end
endmodule
`default_nettype wire
